/* src/tcp_chan.sv */
`timescale 1ns/100ps
module tcp_chan
    import tcp_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // Channel events
    input wire tcp_ctrl_type i_ctrl,
    input wire logic i_active,
    input wire logic i_wrap,
    input wire logic i_match,
    // Pin
    output tcp_pin_type o_pin
);

    tcp_pin_type next_pin;

    always_comb begin
        next_pin.out = o_pin.out;
        next_pin.oe = i_active && (i_ctrl.compare_action_hi || i_ctrl.compare_action_lo);
        if (i_active) begin
            if (i_ctrl.toggle_on_wrap && i_wrap) begin
                next_pin.out = ~o_pin.out;
            end
            // Compare applied after the wrap toggle so a value of zero still acts
            if (i_match) begin
                case ({i_ctrl.compare_action_hi, i_ctrl.compare_action_lo})
                    2'b01: next_pin.out = ~next_pin.out;
                    2'b10: next_pin.out = 1'b0;
                    2'b11: next_pin.out = 1'b1;
                    default: next_pin.out = next_pin.out;
                endcase
            end
            if (i_ctrl.full_duty_force && !i_ctrl.toggle_on_wrap) begin
                next_pin.out = ~i_ctrl.compare_action_lo;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pin <= '0;
        end else begin
            o_pin <= next_pin;
        end
    end

    full_duty_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_active && i_ctrl.full_duty_force && !i_ctrl.toggle_on_wrap)
        |=> (o_pin.out == ~$past(i_ctrl.compare_action_lo)))
        else $error("full duty force not applied");

    no_wrap_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_active && !i_ctrl.toggle_on_wrap && !i_ctrl.full_duty_force && !i_match
         && i_ctrl.compare_action_hi)
        |=> $stable(o_pin.out))
        else $error("pin moved without toggle or compare");

    wrap_toggle_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_active && i_ctrl.toggle_on_wrap && i_wrap && !i_match)
        |=> (o_pin.out != $past(o_pin.out)))
        else $error("pin did not toggle on wrap");

endmodule // tcp_chan

/* src/tcp_defines.svh */
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// Register byte offsets and channel count
`define TCP_OFS_STATUS 8'h00
`define TCP_OFS_MODULO 8'h04
`define TCP_OFS_COUNT 8'h08
`define TCP_OFS_CH_BASE 8'h10
`define TCP_CH_COUNT 3'h6

// Status register fields
`define TCP_ST_WRAP_FLAG 7
`define TCP_ST_WRAP_IRQ_EN 6

// Channel control register fields
`define TCP_CC_EVENT_FLAG 7
`define TCP_CC_PAIR_LINK 5

// Reset values
`define TCP_RST_MODULO 16'hFFFF
`define TCP_RST_VALUE 16'h0000
`define TCP_RST_CTRL 8'h00
`define TCP_RST_PRESCALE 3'h0

// Prescaler select that picks the external clock, not built here
`define TCP_PRESCALE_EXT 3'h7

`endif

/* src/tcp_pkg.sv */
package tcp_pkg;

    typedef struct packed {
        logic channel_event_flag;
        logic channel_irq_en;
        logic pair_link;
        logic unbuffered_mode_sel;
        logic compare_action_hi;
        logic compare_action_lo;
        logic toggle_on_wrap;
        logic full_duty_force;
    } tcp_ctrl_type;

    typedef struct packed {
        logic out;
        logic oe;
    } tcp_pin_type;

    typedef enum logic [2:0] {
        TCP_REG_NONE,
        TCP_REG_STATUS,
        TCP_REG_MODULO,
        TCP_REG_COUNT,
        TCP_REG_CTRL,
        TCP_REG_VALUE
    } tcp_reg_kind_type;

    typedef struct packed {
        tcp_reg_kind_type kind;
        logic [2:0] ch;
    } tcp_dec_type;

    typedef enum logic {
        TCP_APB_IDLE,
        TCP_APB_ANSWER
    } tcp_apb_state_type;

endpackage

/* src/tcp_timer_pwm.sv */
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tcp_timer_pwm
    import tcp_pkg::*;
#(
    parameter int PRE_W = 6
)(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Channel pins
    output logic [5:0] o_ch_pin_out,
    output logic [5:0] o_ch_pin_oe,
    // Interrupt requests
    output logic o_wrap_irq,
    output logic [5:0] o_ch_irq
);

    function automatic tcp_dec_type decode(input logic [7:0] addr);
        tcp_dec_type dec;
        logic [7:0] rel;
        dec.kind = TCP_REG_NONE;
        dec.ch = 3'h0;
        rel = addr - `TCP_OFS_CH_BASE;
        if (addr[1:0] != 2'h0) begin
            dec.kind = TCP_REG_NONE;
        end else if (addr == `TCP_OFS_STATUS) begin
            dec.kind = TCP_REG_STATUS;
        end else if (addr == `TCP_OFS_MODULO) begin
            dec.kind = TCP_REG_MODULO;
        end else if (addr == `TCP_OFS_COUNT) begin
            dec.kind = TCP_REG_COUNT;
        end else if (addr >= `TCP_OFS_CH_BASE && rel[7:6] == 2'h0 && rel[5:3] < `TCP_CH_COUNT) begin
            dec.ch = rel[5:3];
            dec.kind = rel[2] ? TCP_REG_VALUE : TCP_REG_CTRL;
        end
        return dec;
    endfunction

    function automatic logic [PRE_W-1:0] pre_mask(input logic [2:0] sel);
        logic [PRE_W:0] one_hot;
        one_hot = (PRE_W+1)'(1) << sel;
        return PRE_W'(one_hot - (PRE_W+1)'(1));
    endfunction

    // Bus handshake state
    tcp_apb_state_type apb_state, next_apb_state;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    tcp_dec_type dec;
    logic wr;

    // Core state
    logic wrap_flag, next_wrap_flag;
    logic wrap_irq_en, next_wrap_irq_en;
    logic [2:0] prescale_select, next_prescale_select;
    logic [15:0] modulo, next_modulo;
    logic [15:0] count, next_count;
    logic [PRE_W-1:0] pre_cnt, next_pre_cnt;
    logic cnt_upd, next_cnt_upd;
    logic wrapped, next_wrapped;
    tcp_ctrl_type ctrl [6];
    tcp_ctrl_type next_ctrl [6];
    logic [15:0] value [6];
    logic [15:0] next_value [6];
    logic [2:0] sel, next_sel;
    logic [2:0] last, next_last;
    logic next_wrap_irq;
    logic [5:0] next_ch_irq;
    logic [8:0] gap, next_gap;
    logic per_clean, next_per_clean;

    // Derived prescaler tick, and per channel
    logic tick;
    logic [5:0] active;
    logic [5:0] match;
    logic [15:0] act_val [6];
    tcp_pin_type pin [6];

    assign dec = decode(i_paddr);
    assign wr = i_psel && i_penable && o_pready && i_pwrite;

    always_comb begin
        next_apb_state = TCP_APB_IDLE;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        case (apb_state)
            TCP_APB_IDLE: begin
                // One wait state lets the read data come from a flop
                if (i_psel && i_penable) begin
                    next_apb_state = TCP_APB_ANSWER;
                    next_pready = 1'b1;
                    next_pslverr = (dec.kind == TCP_REG_NONE);
                    case (dec.kind)
                        TCP_REG_STATUS: next_prdata = {24'h00_0000, wrap_flag, wrap_irq_en, 3'h0, prescale_select};
                        TCP_REG_MODULO: next_prdata = {16'h0000, modulo};
                        TCP_REG_COUNT: next_prdata = {16'h0000, count};
                        TCP_REG_CTRL: next_prdata = {24'h00_0000, ctrl[dec.ch]};
                        TCP_REG_VALUE: next_prdata = {16'h0000, value[dec.ch]};
                        default: next_prdata = 32'h0000_0000;
                    endcase
                end
            end
            TCP_APB_ANSWER: next_apb_state = TCP_APB_IDLE;
            default: next_apb_state = TCP_APB_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            apb_state <= TCP_APB_IDLE;
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            apb_state <= next_apb_state;
            o_prdata <= next_prdata;
            o_pready <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // Governing value, pin ownership and compare per channel
    always_comb begin
        tick = (prescale_select != `TCP_PRESCALE_EXT)
            && ((pre_cnt & pre_mask(prescale_select)) == pre_mask(prescale_select));
        for (int i = 0; i < 6; i++) begin
            act_val[i] = value[i];
            if (i % 2 == 0) begin
                active[i] = ctrl[i].pair_link || ctrl[i].unbuffered_mode_sel;
                if (ctrl[i].pair_link) begin
                    act_val[i] = sel[i/2] ? value[i | 1] : value[i];
                end
            end else begin
                active[i] = ctrl[i].unbuffered_mode_sel && !ctrl[i & 6].pair_link;
            end
            match[i] = active[i] && cnt_upd && (count == act_val[i]);
        end
    end

    always_comb begin
        next_pre_cnt = pre_cnt + PRE_W'(1);
        next_cnt_upd = tick;
        next_wrapped = tick && (count == modulo);
        next_count = count;
        if (tick) begin
            next_count = (count == modulo) ? 16'h0000 : count + 16'h0001;
        end
        next_wrap_irq_en = wrap_irq_en;
        next_prescale_select = prescale_select;
        next_modulo = modulo;
        next_wrap_flag = wrap_flag;
        next_sel = sel;
        next_last = last;
        for (int i = 0; i < 6; i++) begin
            next_ctrl[i] = ctrl[i];
            next_value[i] = value[i];
        end
        for (int p = 0; p < 3; p++) begin
            if (!ctrl[2*p].pair_link) begin
                next_sel[p] = 1'b0;
                next_last[p] = 1'b0;
            end else if (wrapped) begin
                next_sel[p] = last[p];
            end
        end
        if (wr) begin
            case (dec.kind)
                TCP_REG_STATUS: begin
                    next_wrap_irq_en = i_pwdata[`TCP_ST_WRAP_IRQ_EN];
                    next_prescale_select = i_pwdata[2:0];
                    if (i_pwdata[`TCP_ST_WRAP_FLAG]) begin
                        next_wrap_flag = 1'b0;
                    end
                end
                TCP_REG_MODULO: next_modulo = i_pwdata[15:0];
                TCP_REG_CTRL: begin
                    next_ctrl[dec.ch] = tcp_ctrl_type'({ctrl[dec.ch].channel_event_flag, i_pwdata[6:0]});
                    if (dec.ch[0]) begin
                        next_ctrl[dec.ch].pair_link = 1'b0;
                    end
                    if (i_pwdata[`TCP_CC_EVENT_FLAG]) begin
                        next_ctrl[dec.ch].channel_event_flag = 1'b0;
                    end
                end
                TCP_REG_VALUE: begin
                    next_value[dec.ch] = i_pwdata[15:0];
                    if (ctrl[{dec.ch[2:1], 1'b0}].pair_link) begin
                        next_last[dec.ch[2:1]] = dec.ch[0];
                    end
                end
                default: next_modulo = modulo;
            endcase
        end
        // Hardware set wins over a same-cycle clear
        if (wrapped) begin
            next_wrap_flag = 1'b1;
        end
        for (int i = 0; i < 6; i++) begin
            if (match[i]) begin
                next_ctrl[i].channel_event_flag = 1'b1;
            end
            next_ch_irq[i] = ctrl[i].channel_event_flag && ctrl[i].channel_irq_en && active[i];
        end
        next_wrap_irq = wrap_flag && wrap_irq_en;
        next_gap = wrapped ? 9'h000 : gap + {8'h00, gap != 9'h1FF};
        next_per_clean = (wrapped || per_clean) && modulo == 16'h00FF && prescale_select == 3'h0;
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wrap_flag <= 1'b0;
            wrap_irq_en <= 1'b0;
            prescale_select <= `TCP_RST_PRESCALE;
            modulo <= `TCP_RST_MODULO;
            count <= 16'h0000;
            pre_cnt <= '0;
            cnt_upd <= 1'b0;
            wrapped <= 1'b0;
            sel <= 3'h0;
            last <= 3'h0;
            o_wrap_irq <= 1'b0;
            o_ch_irq <= 6'h00;
            gap <= 9'h000;
            per_clean <= 1'b0;
            for (int i = 0; i < 6; i++) begin
                ctrl[i] <= `TCP_RST_CTRL;
                value[i] <= `TCP_RST_VALUE;
            end
        end else begin
            wrap_flag <= next_wrap_flag;
            wrap_irq_en <= next_wrap_irq_en;
            prescale_select <= next_prescale_select;
            modulo <= next_modulo;
            count <= next_count;
            pre_cnt <= next_pre_cnt;
            cnt_upd <= next_cnt_upd;
            wrapped <= next_wrapped;
            sel <= next_sel;
            last <= next_last;
            o_wrap_irq <= next_wrap_irq;
            o_ch_irq <= next_ch_irq;
            gap <= next_gap;
            per_clean <= next_per_clean;
            for (int i = 0; i < 6; i++) begin
                ctrl[i] <= next_ctrl[i];
                value[i] <= next_value[i];
            end
        end
    end

    for (genvar g = 0; g < 6; g++) begin : g_chan
        tcp_chan u_chan (
            .i_sys_clk(i_sys_clk),
            .i_arst_n(i_arst_n),
            .i_ctrl(ctrl[g]),
            .i_active(active[g]),
            .i_wrap(wrapped),
            .i_match(match[g]),
            .o_pin(pin[g])
        );
        assign o_ch_pin_out[g] = pin[g].out;
        assign o_ch_pin_oe[g] = pin[g].oe;
    end

    sequence roll_s;
        tick && (count == modulo);
    endsequence

    wrap_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        roll_s |=> (count == 16'h0000) ##1 wrap_flag)
        else $error("wrap flag not set after rollover");

    period_256_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (wrapped && per_clean) |-> (gap == 9'h0FF))
        else $error("period is not 256 clocks");

    pair_init_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(ctrl[0].pair_link) |-> (sel[0] == 1'b0) && (act_val[0] == value[0]))
        else $error("lower channel not governing after link");

    pair_handover_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (wrapped && ctrl[2].pair_link) |=> (sel[1] == $past(last[1])))
        else $error("pair did not hand over at overflow");

    pair_write_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (wr && dec.kind == TCP_REG_VALUE && dec.ch == 3'h5 && ctrl[4].pair_link)
        |=> last[2])
        else $error("write to upper channel not recorded");

    upper_free_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ctrl[0].pair_link |=> !o_ch_pin_oe[1])
        else $error("upper pin still driven while linked");

    exact_match_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        match[2] |-> cnt_upd && (count == act_val[2]) ##1 ctrl[2].channel_event_flag)
        else $error("compare without equality or flag");

    apb_answer_a: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
        else $error("bus answer not one cycle after access");

endmodule // tcp_timer_pwm

/* test/tcp_pin_meter.sv */
`timescale 1ns/100ps
module tcp_pin_meter (
    // Clock
    input wire logic i_sys_clk,
    // Pin as driven by the timer
    input wire logic i_pin_out,
    input wire logic i_pin_oe,
    // Measurements
    output logic o_level,
    output int o_high,
    output int o_period
);
    logic prev = 1'b0;
    int run_high = 0;
    int run_all = 0;
    // Pull-down on the board, so a released pin reads low
    assign o_level = i_pin_oe ? i_pin_out : 1'b0;
    // Period is rise to rise, width is rise to fall
    always @(posedge i_sys_clk) begin
        prev <= o_level;
        if (o_level && !prev) begin
            o_period <= run_all;
            run_all <= 1;
            run_high <= 1;
        end else begin
            run_all <= run_all + 1;
            run_high <= run_high + 1;
        end
        if (!o_level && prev) begin
            o_high <= run_high;
        end
    end
endmodule // tcp_pin_meter

/* test/tcp_timer_pwm_test.sv */
`timescale 1ns/100ps
`include "tcp_defines.svh"
module tcp_timer_pwm_test;
    import tcp_pkg::*;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic wrap_irq;
    logic [5:0] ch_irq;
    wire logic [5:0] level;
    int high_w [6];
    int period_w [6];
    int miscompares = 0;
    int tests_run = 0;
    logic [31:0] rdat;
    logic rerr;

    always #5 sys_clk = ~sys_clk;

    tcp_timer_pwm dut (
        .i_sys_clk(sys_clk), .i_arst_n(arst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_ch_pin_out(pin_out), .o_ch_pin_oe(pin_oe), .o_wrap_irq(wrap_irq), .o_ch_irq(ch_irq)
    );

    for (genvar g = 0; g < 6; g++) begin : g_load
        tcp_pin_meter load (
            .i_sys_clk(sys_clk), .i_pin_out(pin_out[g]), .i_pin_oe(pin_oe[g]),
            .o_level(level[g]), .o_high(high_w[g]), .o_period(period_w[g])
        );
    end

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic hang;
        $display("[ERR] wait expected done seen timeout");
        miscompares++;
        report_and_stop();
    endtask

    function automatic void chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
            miscompares++;
        end
    endfunction

    function automatic logic [7:0] ctl(input int ch);
        return `TCP_OFS_CH_BASE + 8'(8 * ch);
    endfunction

    // Held until pready is sampled high, released only after that edge
    task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= adr;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) hang();
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: pick = level[0];
            1: pick = ch_irq[0];
            default: pick = wrap_irq;
        endcase
    endfunction

    task automatic wait_on(input int w, input logic v);
        int n;
        n = 0;
        while (pick(w) !== v) begin
            @(posedge sys_clk);
            n++;
            if (n > 600) hang();
        end
    endtask

    task automatic hold_check(input int ch, input logic v, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge sys_clk);
            if (level[ch] !== v) bad = 1'b1;
        end
        chk("held level", 32'(v), 32'(level[ch] ^ bad));
    endtask

    task automatic t_pwm;
        logic [15:0] mods [2] = '{16'h00FF, 16'h01FF};
        logic [15:0] vals [2] = '{16'h0080, 16'h0180};
        apb(1'b0, `TCP_OFS_MODULO, 32'h0);
        chk("modulo reset", 32'h0000FFFF, rdat);
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, `TCP_OFS_MODULO, {16'h0000, mods[i]});
            apb(1'b1, ctl(0) + 8'h04, {16'h0000, vals[i]});
            apb(1'b1, ctl(0), 32'h0000001A);
            repeat (1600) @(posedge sys_clk);
            chk("period", 32'(mods[i]) + 32'h1, 32'(period_w[0]));
            chk("width", 32'(vals[i]), 32'(high_w[0]));
        end
        chk("idle oe", 32'h0, 32'(pin_oe[1]));
        $display("t_pwm done");
    endtask

    task automatic t_ends;
        // Shrink modulo just after a wrap, else the count runs past it to the 16-bit end
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        apb(1'b1, `TCP_OFS_MODULO, 32'h000000FF);
        apb(1'b1, ctl(0) + 8'h04, 32'h00000040);
        apb(1'b1, ctl(0), 32'h0000001E);
        repeat (600) @(posedge sys_clk);
        chk("set width", 32'hC0, 32'(high_w[0]));
        apb(1'b1, ctl(0) + 8'h04, 32'h00000080);
        apb(1'b1, ctl(0), 32'h00000018);
        repeat (600) @(posedge sys_clk);
        hold_check(0, 1'b0, 300);
        apb(1'b1, ctl(0), 32'h00000019);
        repeat (10) @(posedge sys_clk);
        hold_check(0, 1'b1, 300);
        $display("t_ends done");
    endtask

    task automatic t_link;
        for (int k = 0; k < 6; k += 2) begin
            apb(1'b1, ctl(k) + 8'h04, 32'h00000040);
            apb(1'b1, ctl(k + 1), 32'h0000001A);
            apb(1'b1, ctl(k), 32'h0000003A);
            repeat (600) @(posedge sys_clk);
            chk("lower width", 32'h40, 32'(high_w[k]));
            chk("upper oe", 32'h0, 32'(pin_oe[k + 1]));
            chk("lower oe", 32'h1, 32'(pin_oe[k]));
            apb(1'b1, ctl(k + 1) + 8'h04, 32'h000000C0);
            repeat (600) @(posedge sys_clk);
            chk("upper width", 32'hC0, 32'(high_w[k]));
            apb(1'b1, ctl(k), 32'h0);
            apb(1'b1, ctl(k + 1), 32'h0);
        end
        $display("t_link done");
    endtask

    // Value lowered below the running count: that period has no compare
    task automatic t_missed;
        apb(1'b1, ctl(0) + 8'h04, 32'h00000080);
        apb(1'b1, ctl(0), 32'h0000001A);
        repeat (600) @(posedge sys_clk);
        wait_on(0, 1'b0);
        wait_on(0, 1'b1);
        repeat (80) @(posedge sys_clk);
        apb(1'b1, ctl(0) + 8'h04, 32'h00000030);
        apb(1'b1, ctl(0), 32'h0000009A);
        repeat (96) @(posedge sys_clk);
        apb(1'b0, ctl(0), 32'h0);
        chk("no compare", 32'h0, 32'(rdat[7]));
        repeat (256) @(posedge sys_clk);
        apb(1'b0, ctl(0), 32'h0);
        chk("compare flag", 32'h1, 32'(rdat[7]));
        $display("t_missed done");
    endtask

    task automatic t_irq;
        apb(1'b1, ctl(0), 32'h000000DA);
        wait_on(1, 1'b1);
        apb(1'b1, ctl(0) + 8'h04, 32'h00000020);
        repeat (300) @(posedge sys_clk);
        chk("lowered width", 32'h20, 32'(high_w[0]));
        apb(1'b1, `TCP_OFS_STATUS, 32'h000000C0);
        wait_on(2, 1'b1);
        apb(1'b1, ctl(0) + 8'h04, 32'h00000060);
        apb(1'b0, `TCP_OFS_STATUS, 32'h0);
        chk("wrap flag", 32'h1, 32'(rdat[7]));
        repeat (300) @(posedge sys_clk);
        chk("raised width", 32'h60, 32'(high_w[0]));
        apb(1'b1, `TCP_OFS_STATUS, 32'h00000080);
        repeat (2) @(posedge sys_clk);
        chk("wrap irq gated", 32'h0, 32'(wrap_irq));
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped err", 32'h1, 32'(rerr));
        $display("t_irq done");
    endtask

    initial begin
        repeat (4) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        t_pwm();
        t_ends();
        t_link();
        t_missed();
        t_irq();
        report_and_stop();
    end
endmodule // tcp_timer_pwm_test
